// [src/ceeu_pkg.sv]
// Constants and event table shared by the exception entry unit.
package ceeu_pkg;

  // Memory-mapped register addresses, P4 view and area 7 view.
  localparam logic [31:0] ADDR_TRAP_IMM = 32'hff000020;
  localparam logic [31:0] ADDR_EXC_CODE = 32'hff000024;
  localparam logic [31:0] ADDR_IRQ_CODE = 32'hff000028;
  localparam logic [31:0] AREA7_MASK    = 32'h1fffffff;

  // Register field widths and reset values.
  localparam int          CODE_W        = 12;
  localparam int          TRAP_W        = 8;
  localparam logic [11:0] EXC_CODE_RST  = 12'h000;
  localparam logic [11:0] IRQ_CODE_RST  = 12'h000;
  localparam logic [7:0]  TRAP_IMM_RST  = 8'h00;

  // Status word bit positions.
  localparam int SR_MD = 30;
  localparam int SR_RB = 29;
  localparam int SR_BL = 28;
  localparam int SR_FD = 15;

  // Vector addresses and offsets.
  localparam logic [31:0] RESET_VECTOR = 32'ha0000000;
  localparam logic [11:0] OFF_GENERAL  = 12'h100;
  localparam logic [11:0] OFF_TLB_MISS = 12'h400;
  localparam logic [11:0] OFF_IRQ      = 12'h600;
  localparam logic [11:0] OFF_NONE     = 12'h000;

  // Event indices, one request line each.
  localparam int NUM_EV   = 23;
  localparam int EV_W     = 5;
  localparam int EV_PWRON = 0;
  localparam int EV_MANRS = 1;
  localparam int EV_DBGRS = 2;
  localparam int EV_UBRKB = 5;
  localparam int EV_TRAP  = 21;
  localparam int EV_UBRKA = 22;

  // Priority level 1 marks the reset class.
  localparam logic [1:0] LVL_RESET = 2'h1;
  localparam logic [1:0] LVL_GEN   = 2'h2;

  // Per-event code, level, order and offset, indexed by event number.
  localparam logic [11:0] EV_CODE [0:NUM_EV-1] = '{
    12'h000, 12'h020, 12'h000, 12'h140, 12'h140, 12'h1e0,
    12'h0e0, 12'h040, 12'h0a0, 12'h180, 12'h1a0, 12'h800,
    12'h820, 12'h0e0, 12'h100, 12'h040, 12'h060, 12'h0a0,
    12'h0c0, 12'h120, 12'h080, 12'h160, 12'h1e0};
  localparam logic [1:0] EV_LVL [0:NUM_EV-1] = '{
    2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h2, 2'h2, 2'h2, 2'h2,
    2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2,
    2'h2, 2'h2, 2'h2, 2'h2, 2'h2};
  localparam logic [3:0] EV_ORD [0:NUM_EV-1] = '{
    4'h1, 4'h2, 4'h1, 4'h3, 4'h4, 4'h0, 4'h1, 4'h2, 4'h3,
    4'h4, 4'h4, 4'h4, 4'h4, 4'h5, 4'h5, 4'h6, 4'h6, 4'h7,
    4'h7, 4'h8, 4'h9, 4'h4, 4'ha};
  localparam logic [11:0] EV_OFF [0:NUM_EV-1] = '{
    12'h000, 12'h000, 12'h000, 12'h000, 12'h000, 12'h100,
    12'h100, 12'h400, 12'h100, 12'h100, 12'h100, 12'h100,
    12'h100, 12'h100, 12'h100, 12'h400, 12'h400, 12'h100,
    12'h100, 12'h100, 12'h100, 12'h100, 12'h100};

  // Entry sequence states, Gray coded from ST_IDLE to ST_JUMP; the return to ST_IDLE flips both bits.
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SAVE = 2'b01,
    ST_JUMP = 2'b11
  } ceeu_state_t;

endpackage

// [src/ceeu_prio.sv]
// Picks the winning exception among simultaneous requests.
`timescale 1ns/100ps
`default_nettype none
module ceeu_prio
(
  ceeu_sel_if.prio sel
);
  import ceeu_pkg::*;

  logic [5:0] key [0:NUM_EV-1];

  // Rank key per entry; idle lines get the worst key.
  genvar gi;
  generate
    for (gi = 0; gi < NUM_EV; gi = gi + 1)
    begin : g_key
      assign key[gi] = sel.req[gi] ? {EV_LVL[gi], EV_ORD[gi]}
                                   : 6'h3f;
    end
  endgenerate

  // Lowest level, then lowest order; ties go to the lower index.
  always_comb
  begin
    logic [5:0] best;
    best         = 6'h3f;
    sel.valid    = 1'b0;
    sel.idx      = '0;
    sel.code     = 12'h000;
    sel.offset   = 12'h000;
    sel.is_reset = 1'b0;
    for (int i = 0; i < NUM_EV; i++)
    begin
      if (sel.req[i] && key[i] < best)
      begin
        best         = key[i];
        sel.valid    = 1'b1;
        sel.idx      = EV_W'(i);
        sel.code     = EV_CODE[i];
        sel.offset   = EV_OFF[i];
        sel.is_reset = (EV_LVL[i] == LVL_RESET);
      end
    end
  end
endmodule
`default_nettype wire

// [src/ceeu_sel_if.sv]
// Carrier between the entry sequencer and the event priority picker.
`timescale 1ns/100ps
`default_nettype none
interface ceeu_sel_if;
  import ceeu_pkg::*;
  logic [NUM_EV-1:0] req;
  logic              valid;
  logic [EV_W-1:0]   idx;
  logic [11:0]       code;
  logic [11:0]       offset;
  logic              is_reset;

  modport prio
  (
    input  req,
    output valid,
    output idx,
    output code,
    output offset,
    output is_reset
  );
  modport core
  (
    output req,
    input  valid,
    input  idx,
    input  code,
    input  offset,
    input  is_reset
  );
endinterface
`default_nettype wire

// [src/ceeu_top.sv]
// Exception entry unit: event capture, context save and vector select.
`timescale 1ns/100ps
`default_nettype none
module ceeu_top
(
  input  wire logic                        mclk,
  input  wire logic                        reset,
  // Exception requests, held by the source until entry_taken.
  input  wire logic [ceeu_pkg::NUM_EV-1:0] event_req,
  input  wire logic                        irq_req,
  input  wire logic [11:0]                 irq_code,
  input  wire logic [7:0]                  trap_imm,
  input  wire logic                        ubrk_use_debug_base,
  // Core context seen at the moment of entry.
  input  wire logic [31:0]                 pc,
  input  wire logic [31:0]                 status_word,
  input  wire logic [31:0]                 gpr15,
  input  wire logic [31:0]                 vector_base,
  input  wire logic [31:0]                 debug_base,
  input  wire logic                        return_from_exception,
  // Memory-mapped register port.
  input  wire logic                        reg_req,
  input  wire logic                        reg_write,
  input  wire logic [31:0]                 reg_addr,
  input  wire logic [31:0]                 reg_wdata,
  output logic                             reg_ack,
  output logic [31:0]                      reg_rdata,
  // Entry results toward the pipeline.
  output logic                             entry_taken,
  output logic                             entry_is_irq,
  output logic [ceeu_pkg::EV_W-1:0]        entry_event,
  output logic [31:0]                      saved_pc,
  output logic [31:0]                      saved_status,
  output logic [31:0]                      saved_r15,
  output logic                             status_load,
  output logic [31:0]                      status_next,
  output logic                             branch_valid,
  output logic [31:0]                      branch_addr,
  output logic                             restore_valid,
  output logic [31:0]                      restore_pc,
  output logic [31:0]                      restore_status
);
  import ceeu_pkg::*;

  ceeu_state_t       state;
  ceeu_state_t       next_state;
  ceeu_sel_if        sel ();

  logic              pend_irq;
  logic              pend_reset;
  logic              pend_trap;
  logic [EV_W-1:0]   pend_idx;
  logic [11:0]       pend_code;
  logic [31:0]       pend_vector;
  logic [31:0]       next_vector;
  logic              irq_ok;
  logic              start;

  logic [11:0]       exc_code;
  logic [11:0]       irq_code_r;
  logic [7:0]        trap_cap;

  logic              addr_trap;
  logic              addr_exc;
  logic              addr_irq;
  logic              sw_wr;

  // The picker sees the raw request lines.
  assign sel.req = event_req;

  ceeu_prio u_prio
  (
    .sel (sel)
  );

  // Interrupts wait while the block bit is set or an exception is
  // pending; exceptions always outrank them.
  assign irq_ok = irq_req && !status_word[SR_BL] && !sel.valid;
  assign start  = (state == ST_IDLE) && (sel.valid || irq_ok);

  // Vector for the winning event, worked out before the latch.
  always_comb
  begin
    if (!sel.valid)
      next_vector = vector_base + {20'h00000, OFF_IRQ};
    else if (sel.is_reset)
      next_vector = RESET_VECTOR;
    else if ((sel.idx == EV_W'(EV_UBRKB) ||
              sel.idx == EV_W'(EV_UBRKA)) && ubrk_use_debug_base)
      next_vector = debug_base;
    else
      next_vector = vector_base + {20'h00000, sel.offset};
  end

  // Entry sequence: latch, save, branch.
  always_comb
  begin
    case (state)
      ST_IDLE:
        next_state = start ? ST_SAVE : ST_IDLE;
      ST_SAVE:
        next_state = ST_JUMP;
      ST_JUMP:
        next_state = ST_IDLE;
      default:
        next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      state <= ST_IDLE;
    else
      state <= next_state;
  end

  // Winning event held for the rest of the sequence; the sources
  // may drop their request once entry_taken is seen.
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      pend_irq    <= 1'b0;
      pend_reset  <= 1'b0;
      pend_trap   <= 1'b0;
      pend_idx    <= '0;
      pend_code   <= 12'h000;
      pend_vector <= 32'h00000000;
    end
    else if (start)
    begin
      pend_irq    <= !sel.valid;
      pend_reset  <= sel.valid && sel.is_reset;
      pend_trap   <= sel.valid && sel.idx == EV_W'(EV_TRAP);
      pend_idx    <= sel.idx;
      pend_code   <= sel.valid ? sel.code : irq_code;
      pend_vector <= next_vector;
    end
  end

  // Context save and forced status bits in the save cycle.
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      saved_pc     <= 32'h00000000;
      saved_status <= 32'h00000000;
      saved_r15    <= 32'h00000000;
      status_next  <= 32'h00000000;
      status_load  <= 1'b0;
      entry_taken  <= 1'b0;
      entry_is_irq <= 1'b0;
      entry_event  <= '0;
    end
    else
    begin
      status_load <= 1'b0;
      entry_taken <= 1'b0;
      if (state == ST_SAVE)
      begin
        saved_pc            <= pc;
        saved_status        <= status_word;
        saved_r15           <= gpr15;
        status_next         <= status_word;
        status_next[SR_BL]  <= 1'b1;
        status_next[SR_MD]  <= 1'b1;
        status_next[SR_RB]  <= 1'b1;
        // The FPU stays as software left it unless this is a reset.
        status_next[SR_FD]  <= pend_reset ? 1'b0
                                          : status_word[SR_FD];
        status_load         <= 1'b1;
        entry_taken         <= 1'b1;
        entry_is_irq        <= pend_irq;
        entry_event         <= pend_idx;
      end
    end
  end

  // Branch is issued one cycle after the code register is written,
  // so a handler that reads the code sees the new value.
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      branch_valid <= 1'b0;
      branch_addr  <= 32'h00000000;
    end
    else
    begin
      branch_valid <= (state == ST_JUMP);
      if (state == ST_JUMP)
        branch_addr <= pend_vector;
    end
  end

  // Return path: saved_r15 is deliberately not handed back.
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      restore_valid  <= 1'b0;
      restore_pc     <= 32'h00000000;
      restore_status <= 32'h00000000;
    end
    else
    begin
      restore_valid <= 1'b0;
      if (return_from_exception && state == ST_IDLE && !start)
      begin
        restore_valid  <= 1'b1;
        restore_pc     <= saved_pc;
        restore_status <= saved_status;
      end
    end
  end

  // Register decode; the area 7 alias maps onto the same words.
  assign addr_trap = (reg_addr & AREA7_MASK) == (ADDR_TRAP_IMM & AREA7_MASK);
  assign addr_exc  = (reg_addr & AREA7_MASK) == (ADDR_EXC_CODE & AREA7_MASK);
  assign addr_irq  = (reg_addr & AREA7_MASK) == (ADDR_IRQ_CODE & AREA7_MASK);
  assign sw_wr     = reg_req && reg_write;

  // Exception code register; a hardware load in the same cycle as
  // a software write wins, so the event is never lost.
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      exc_code <= EXC_CODE_RST;
    else if (state == ST_SAVE && !pend_irq)
      exc_code <= pend_code;
    else if (sw_wr && addr_exc)
      exc_code <= reg_wdata[CODE_W-1:0];
  end

  // Interrupt code register, same precedence.
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      irq_code_r <= IRQ_CODE_RST;
    else if (state == ST_SAVE && pend_irq)
      irq_code_r <= pend_code;
    else if (sw_wr && addr_irq)
      irq_code_r <= reg_wdata[CODE_W-1:0];
  end

  // Trap immediate; the operand is taken in the save cycle, when
  // the trapping instruction still presents it.
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      trap_cap <= TRAP_IMM_RST;
    else if (state == ST_SAVE && pend_trap)
      trap_cap <= trap_imm;
    else if (sw_wr && addr_trap)
      trap_cap <= reg_wdata[TRAP_W-1:0];
  end

  // Read data one cycle after the request; unmapped reads give zero.
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      reg_ack   <= 1'b0;
      reg_rdata <= 32'h00000000;
    end
    else
    begin
      reg_ack <= reg_req;
      if (reg_req && !reg_write)
      begin
        if (addr_exc)
          reg_rdata <= {20'h00000, exc_code};
        else if (addr_irq)
          reg_rdata <= {20'h00000, irq_code_r};
        else if (addr_trap)
          reg_rdata <= {24'h000000, trap_cap};
        else
          reg_rdata <= 32'h00000000;
      end
    end
  end

endmodule
`default_nettype wire

// [tb/ceeu_properties.sv]
// Port-level checker for entry timing, status forcing and vectors.
`timescale 1ns/100ps
`default_nettype none
module ceeu_properties
(
  input wire logic                      mclk,
  input wire logic                      reset,
  input wire logic [31:0]               pc,
  input wire logic [31:0]               status_word,
  input wire logic [31:0]               gpr15,
  input wire logic [31:0]               vector_base,
  input wire logic                      ubrk_use_debug_base,
  input wire logic                      entry_taken,
  input wire logic                      entry_is_irq,
  input wire logic [ceeu_pkg::EV_W-1:0] entry_event,
  input wire logic [31:0]               saved_pc,
  input wire logic [31:0]               saved_status,
  input wire logic [31:0]               saved_r15,
  input wire logic                      status_load,
  input wire logic [31:0]               status_next,
  input wire logic                      branch_valid,
  input wire logic [31:0]               branch_addr,
  input wire logic                      restore_valid,
  input wire logic [31:0]               restore_pc,
  input wire logic [31:0]               restore_status
);
  import ceeu_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  // Vector base is sampled at acceptance, three cycles before the branch.
  property p_branch;
    entry_taken |=> branch_valid ##1 !branch_valid;
  endproperty
  a_branch: assert property (p_branch)
    else $error("branch not one cycle after entry");
  property p_spacing;
    entry_taken |=> !entry_taken [*2];
  endproperty
  a_spacing: assert property (p_spacing)
    else $error("entries closer than three cycles");
  property p_save;
    entry_taken |-> saved_pc == $past(pc) && saved_r15 == $past(gpr15)
      && saved_status == $past(status_word);
  endproperty
  a_save: assert property (p_save)
    else $error("context not saved from the save cycle");
  property p_force;
    status_load |-> entry_taken && status_next[30:28] == 3'b111;
  endproperty
  a_force: assert property (p_force)
    else $error("status bits not forced on entry");
  property p_fd;
    status_load |-> status_next[15] ==
      ((!entry_is_irq && entry_event < 5) ? 1'b0 : $past(status_word[15]));
  endproperty
  a_fd: assert property (p_fd)
    else $error("fpu disable bit handled wrongly");
  property p_rst_vec;
    entry_taken && !entry_is_irq && entry_event < 5 |=>
      branch_addr == 32'ha0000000;
  endproperty
  a_rst_vec: assert property (p_rst_vec)
    else $error("reset class vector wrong");
  property p_gen_vec;
    entry_taken && !entry_is_irq && entry_event > 4 && !ubrk_use_debug_base
      |=> branch_addr - $past(vector_base, 3) inside {32'h100, 32'h400};
  endproperty
  a_gen_vec: assert property (p_gen_vec)
    else $error("general vector not base plus offset");
  property p_irq_vec;
    entry_taken && entry_is_irq |=>
      branch_addr == $past(vector_base, 3) + 32'h600;
  endproperty
  a_irq_vec: assert property (p_irq_vec)
    else $error("interrupt vector wrong");
  property p_restore;
    restore_valid |-> restore_pc == saved_pc && restore_status == saved_status;
  endproperty
  a_restore: assert property (p_restore)
    else $error("return does not restore saved context");
endmodule
bind ceeu_top ceeu_properties ceeu_properties_i (.mclk, .reset, .pc,
  .status_word, .gpr15, .vector_base, .ubrk_use_debug_base, .entry_taken,
  .entry_is_irq, .entry_event, .saved_pc, .saved_status, .saved_r15,
  .status_load, .status_next, .branch_valid, .branch_addr, .restore_valid,
  .restore_pc, .restore_status);
`default_nettype wire

// [tb/ceeu_src.sv]
// Model of the pipeline that raises exception and interrupt requests.
`timescale 1ns/100ps
`default_nettype none
module ceeu_src
(
  input  wire logic                        mclk,
  input  wire logic                        reset,
  input  wire logic                        fire,
  input  wire logic [ceeu_pkg::NUM_EV-1:0] fire_ev,
  input  wire logic                        fire_irq,
  input  wire logic                        entry_taken,
  input  wire logic                        entry_is_irq,
  input  wire logic [ceeu_pkg::EV_W-1:0]   entry_event,
  output logic      [ceeu_pkg::NUM_EV-1:0] event_req,
  output logic                             irq_req
);
  import ceeu_pkg::*;
  logic [NUM_EV-1:0] done_ev;

  // Only the reported event retires; a raise in the same cycle must not
  // hide that retirement, or a served request would be taken again.
  assign done_ev = (entry_taken && !entry_is_irq) ?
                   NUM_EV'(1) << entry_event : '0;

  // A request stays up until its own entry is reported, so a loser waits.
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      event_req <= '0;
      irq_req   <= 1'b0;
    end
    else
    begin
      event_req <= (event_req & ~done_ev) | (fire ? fire_ev : '0);
      irq_req   <= (irq_req && !(entry_taken && entry_is_irq)) ||
                   (fire && fire_irq);
    end
  end
endmodule
`default_nettype wire

// [tb/ceeu_top_tb.sv]
// Self-checking bench for the exception entry unit.
`timescale 1ns/100ps
`default_nettype none
module ceeu_top_tb;
  import ceeu_pkg::*;
  // Handler bases sit in an untranslated region, as software must keep them.
  localparam logic [31:0] VB = 32'h8c000000;
  localparam logic [31:0] DB = 32'h8c100000;
  localparam logic [11:0] EXP_CODE [0:22] = '{12'h000, 12'h020, 12'h000,
    12'h140, 12'h140, 12'h1e0, 12'h0e0, 12'h040, 12'h0a0, 12'h180, 12'h1a0,
    12'h800, 12'h820, 12'h0e0, 12'h100, 12'h040, 12'h060, 12'h0a0, 12'h0c0,
    12'h120, 12'h080, 12'h160, 12'h1e0};
  logic              mclk = 1'b0, reset = 1'b1, fire = 1'b0, fire_irq = 1'b0;
  logic              ubrk = 1'b0, rfe = 1'b0, reg_req = 1'b0, reg_write = 1'b0;
  logic [NUM_EV-1:0] fire_ev = '0, event_req;
  logic [31:0]       status_word = 32'h00008000, reg_addr = '0, reg_wdata = '0;
  logic [11:0]       irq_code = 12'h3c0;
  logic [31:0]       pc = 32'h0c001234;
  logic              irq_req, reg_ack, entry_taken, entry_is_irq, status_load;
  logic              branch_valid, restore_valid;
  logic [EV_W-1:0]   entry_event;
  logic [31:0]       reg_rdata, saved_pc, saved_status, saved_r15, status_next;
  logic [31:0]       branch_addr, restore_pc, restore_status;
  int                error_cnt = 0, check_count = 0, cycles = 0;

  ceeu_top ceeu_top_i (.mclk, .reset, .event_req, .irq_req, .irq_code,
    .trap_imm(8'h5a), .ubrk_use_debug_base(ubrk), .pc,
    .status_word, .gpr15(32'h0c00fff0), .vector_base(VB), .debug_base(DB),
    .return_from_exception(rfe), .reg_req, .reg_write, .reg_addr, .reg_wdata,
    .reg_ack, .reg_rdata, .entry_taken, .entry_is_irq, .entry_event,
    .saved_pc, .saved_status, .saved_r15, .status_load, .status_next,
    .branch_valid, .branch_addr, .restore_valid, .restore_pc,
    .restore_status);
  ceeu_src ceeu_src_i (.mclk, .reset, .fire, .fire_ev, .fire_irq,
    .entry_taken, .entry_is_irq, .entry_event, .event_req, .irq_req);

  always #2 mclk = ~mclk;

  // Caps the run in case the design never answers.
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      error_cnt++;
      report_and_stop();
    end
  end

  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, got);
    check_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Register access; entered just after an edge, ack is due one edge later.
  // An idle cycle follows, so a second call never re-raises the strobe in
  // the same time step that lowered it.
  task automatic reg_rw(input logic wr, input logic [31:0] a, d, exp);
    reg_req = 1'b1;
    reg_write = wr;
    reg_addr = a;
    reg_wdata = d;
    @(posedge mclk) #1;
    reg_req = 1'b0;
    check("reg_ack", 1, reg_ack);
    if (!wr)
      check("reg_rdata", exp, reg_rdata);
    @(posedge mclk) #1;
  endtask

  task automatic raise(input logic [NUM_EV-1:0] v, input logic i);
    fire = 1'b1;
    fire_ev = v;
    fire_irq = i;
    @(posedge mclk) #1;
    fire = 1'b0;
  endtask

  task automatic wait_entry;
    for (int n = 0; n < 20 && entry_taken !== 1'b1; n++)
      @(posedge mclk) #1;
    check("entry_taken", 1, entry_taken);
  endtask

  task automatic t_regs;
    reg_rw(0, ADDR_EXC_CODE, 0, 0);
    reg_rw(1, ADDR_TRAP_IMM, 32'h000000a5, 0);
    reg_rw(0, 32'h1f000020, 0, 32'h000000a5);
    reg_rw(1, ADDR_EXC_CODE, 32'h00000123, 0);
    reg_rw(0, ADDR_EXC_CODE, 0, 32'h00000123);
    reg_rw(1, ADDR_IRQ_CODE, 32'h000003e0, 0);
    reg_rw(0, ADDR_IRQ_CODE, 0, 32'h000003e0);
    reg_rw(0, 32'hff00002c, 0, 0);
  endtask

  // Every event alone: index, forced status, vector and recorded code.
  task automatic t_events;
    logic [31:0] ea;
    for (int i = 0; i < NUM_EV; i++)
    begin
      ubrk = (i == 22);
      pc = 32'h0c001000 + 32'(4 * i);
      raise(NUM_EV'(1) << i, 1'b0);
      wait_entry();
      check("entry_event", i, entry_event);
      check("saved_pc", pc, saved_pc);
      check("status_load", 1, status_load);
      ea = (i < 5) ? 32'h00000000 : 32'h00008000;
      check("status_next", ea | 32'h70000000, status_next);
      @(posedge mclk) #1;
      check("branch_valid", 1, branch_valid);
      ea = (EXP_CODE[i] inside {12'h040, 12'h060}) ? 32'h400 : 32'h100;
      ea = (i < 5) ? 32'ha0000000 : ubrk ? DB : VB + ea;
      check("branch_addr", ea, branch_addr);
      reg_rw(0, ADDR_EXC_CODE, 0, {20'h0, EXP_CODE[i]});
    end
    ubrk = 1'b0;
    reg_rw(0, ADDR_TRAP_IMM, 0, 32'h0000005a);
  endtask

  // Two events together: the first of each pair must win.
  task automatic t_prio;
    int wa [6] = '{0, 1, 9, 5, 20, 4};
    int wb [6] = '{1, 3, 21, 6, 22, 5};
    for (int k = 0; k < 6; k++)
    begin
      raise((NUM_EV'(1) << wa[k]) | (NUM_EV'(1) << wb[k]), 1'b0);
      wait_entry();
      check("winner", wa[k], entry_event);
      @(posedge mclk) #1;
      wait_entry();
      check("loser", wb[k], entry_event);
    end
  endtask

  task automatic t_irq_rfe;
    status_word = 32'h10000000;
    pc = 32'h0c001234;
    raise('0, 1'b1);
    repeat (6) @(posedge mclk);
    #1;
    check("irq_pending", 1, irq_req);
    status_word = 32'h00000000;
    wait_entry();
    check("entry_is_irq", 1, entry_is_irq);
    @(posedge mclk) #1;
    check("branch_addr", VB + 32'h600, branch_addr);
    reg_rw(0, ADDR_IRQ_CODE, 0, 32'h000003c0);
    rfe = 1'b1;
    @(posedge mclk) #1;
    rfe = 1'b0;
    check("restore_valid", 1, restore_valid);
    check("restore_pc", 32'h0c001234, restore_pc);
    check("restore_status", 32'h00000000, restore_status);
    check("saved_r15", 32'h0c00fff0, saved_r15);
  endtask

  initial
  begin
    repeat (16) @(posedge mclk);
    #1;
    reset = 1'b0;
    t_regs();
    t_events();
    t_prio();
    t_irq_rfe();
    report_and_stop();
  end
endmodule
`default_nettype wire
